// >>> design/nicc_command.sv
// nicc_command: core command register with run, stop, transmit, page
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - writing halt_bit high takes the core offline; no new frames start
// - a frame already in progress finishes before the reset state is entered
// - reset-done flag pulses only once the software reset has taken effect
// - run_bit activates the core; at power-up halt reads 1 and run 0
// - halting from running leaves both halt and run reading set
// - transmit_go launches a transmission; cleared when it completes or aborts
// - writing 0 to transmit_go leaves a running transmission alone
// - reissued dma with transmit and no count reload finishes at once
// - page, abort and halt bits accepted at any time
// - setting the top dma command bit aborts any remote dma
// - abort leaves remote start address at its advanced value
// - dma field: 000 none, 001 read, 010 write, 011 send, 1xx abort
// - page bits select register page 0, 1, 2; 3 reserved
module nicc_command
    import nicc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // host register port (isa style, external pins)
    input  wire logic       host_cs,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [3:0] host_addr,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    output logic            cmd_sel,
    // activity of the core engines
    input  wire logic       rx_busy,
    input  wire logic       tx_busy,
    input  wire logic       tx_done,
    input  wire logic       tx_abort,
    input  wire logic       dma_count_reloaded,
    // controls out
    output logic            core_enable,
    output logic            tx_launch,
    output logic            reset_done,
    output logic      [1:0] page_sel,
    output logic      [2:0] rdma_cmd,
    output nicc_dma_t       dma_ctl
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    nicc_host_t host_in;
    nicc_host_t host_s1;
    nicc_host_t host_s2;
    logic       wr_d;
    logic       rd_d;
    logic [1:0] busy_s1;
    logic [1:0] busy_s2;

    assign host_in = '{cs: host_cs, wr: host_wr, rd: host_rd,
                       addr: host_addr, wdata: host_wdata};

    always_ff @(posedge clk) begin
        host_s1 <= host_in;
        host_s2 <= host_s1;
        busy_s1 <= {rx_busy, tx_busy};
        busy_s2 <= busy_s1;
        if (rst) begin
            wr_d <= 1'b0;
            rd_d <= 1'b0;
        end else begin
            wr_d <= host_s2.cs & host_s2.wr;
            rd_d <= host_s2.cs & host_s2.rd;
        end
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    wire       sel_cmd  = host_s2.addr == CMD_OFFSET;
    wire       wr_now   = host_s2.cs & host_s2.wr;
    wire       wr_evt   = wr_now & ~wr_d & sel_cmd;
    wire       rd_evt   = host_s2.cs & host_s2.rd & ~rd_d & sel_cmd;
    wire [7:0] wd       = host_s2.wdata;
    wire       w_halt   = wd[HALT_POS];
    wire       w_run    = wd[RUN_POS];
    wire       w_xmit   = wd[XMIT_POS];
    wire [2:0] w_rdma   = wd[RDMA_MSB:RDMA_LSB];
    wire [1:0] w_page   = wd[PAGE_MSB:PAGE_LSB];
    wire       busy_any = busy_s2[1] | busy_s2[0];

    // ****************************************************************
    // run state
    // ****************************************************************
    nicc_state_t state;
    nicc_state_t next_state;
    logic        halt;
    logic        run;
    logic        xmit;

    always_comb begin
        next_state = state;
        unique case (state)
            NICC_STOPPED: begin
                if (wr_evt && w_run && !w_halt)
                    next_state = NICC_RUNNING;
            end
            NICC_RUNNING: begin
                if (wr_evt && w_halt)
                    next_state = NICC_DRAINING;
            end
            NICC_DRAINING: begin
                if (!busy_any)
                    next_state = NICC_STOPPED;
            end
            default: next_state = NICC_STOPPED;
        endcase
    end

    wire enter_stop = (state == NICC_DRAINING) && !busy_any;
    wire tx_end     = tx_done | tx_abort;
    wire tx_new     = wr_evt & w_xmit & ~xmit & (state == NICC_RUNNING)
                    & ~w_halt;

    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= NICC_STOPPED;
            halt       <= CMD_RESET[HALT_POS];
            run        <= CMD_RESET[RUN_POS];
            xmit       <= CMD_RESET[XMIT_POS];
            rdma_cmd   <= RDMA_RESET;
            page_sel   <= PAGE_RESET;
            reset_done <= 1'b0;
            tx_launch  <= 1'b0;
        end else begin
            state      <= next_state;
            reset_done <= enter_stop;
            tx_launch  <= tx_new;
            if (wr_evt) begin
                page_sel <= w_page;
                rdma_cmd <= w_rdma;
                halt     <= w_halt;
                // run stays set when halting from running
                run      <= w_run | (w_halt & run);
            end
            // writing 0 never clears a pending transmit
            if (tx_new)
                xmit <= 1'b1;
            else if (tx_end)
                xmit <= 1'b0;
        end
    end

    assign core_enable = (state == NICC_RUNNING);

    // ****************************************************************
    // remote dma strobes
    // ****************************************************************
    nicc_rdma_decode u_rdma (
        .wr_en          (wr_evt),
        .cmd            (w_rdma),
        .xmit_set       (w_xmit),
        .count_reloaded (dma_count_reloaded),
        .dma            (dma_ctl)
    );
    // abort only strobes the engine; start address is never rewound

    // ****************************************************************
    // readback
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            host_rdata <= CMD_RESET;
            cmd_sel    <= 1'b0;
        end else begin
            cmd_sel <= sel_cmd;
            if (rd_evt)
                host_rdata <= {page_sel, rdma_cmd, xmit, run, halt};
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_halt_offline;
        @(posedge clk) disable iff (rst)
        (wr_evt && w_halt) |=> !core_enable;
    endproperty
    a_halt_offline: assert property (p_halt_offline)
        else $error("core still enabled after halt");

    property p_drain;
        @(posedge clk) disable iff (rst)
        (state == NICC_DRAINING && busy_any) |=> state == NICC_DRAINING;
    endproperty
    a_drain: assert property (p_drain)
        else $error("stopped while a frame was active");

    sequence s_stop_taken;
        state == NICC_DRAINING && !busy_any;
    endsequence
    property p_reset_done;
        @(posedge clk) disable iff (rst)
        s_stop_taken |=> reset_done ##1 !reset_done;
    endproperty
    a_reset_done: assert property (p_reset_done)
        else $error("reset done not pulsed after stop");

    property p_done_cause;
        @(posedge clk) disable iff (rst)
        reset_done |-> $past(enter_stop);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("reset done without stop");

    property p_start;
        @(posedge clk) disable iff (rst)
        (state == NICC_STOPPED && wr_evt && w_run && !w_halt)
            |=> core_enable;
    endproperty
    a_start: assert property (p_start)
        else $error("run did not enable core");

    property p_both_set;
        @(posedge clk) disable iff (rst)
        (wr_evt && w_halt && run) |=> (halt && run);
    endproperty
    a_both_set: assert property (p_both_set)
        else $error("halt from run lost run bit");

    property p_xmit_hold;
        @(posedge clk) disable iff (rst)
        (xmit && !tx_end) |=> xmit;
    endproperty
    a_xmit_hold: assert property (p_xmit_hold)
        else $error("transmit cleared without completion");

    property p_xmit_clear;
        @(posedge clk) disable iff (rst)
        (tx_end && !tx_new) |=> !xmit;
    endproperty
    a_xmit_clear: assert property (p_xmit_clear)
        else $error("transmit not cleared on completion");

    property p_abort;
        @(posedge clk) disable iff (rst)
        (wr_evt && w_rdma[2]) |-> dma_ctl.abort ##1 rdma_cmd[2];
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort not issued");

    property p_page;
        @(posedge clk) disable iff (rst)
        wr_evt |=> page_sel == $past(w_page);
    endproperty
    a_page: assert property (p_page)
        else $error("page write not accepted");
endmodule
`default_nettype wire

// >>> design/nicc_pkg.sv
// nicc_pkg: constants and types for the core command register
package nicc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0] CMD_OFFSET     = 4'h0;
    localparam logic [7:0] CMD_RESET      = 8'h21;
    localparam int         HALT_POS       = 0;
    localparam int         RUN_POS        = 1;
    localparam int         XMIT_POS       = 2;
    localparam int         RDMA_LSB       = 3;
    localparam int         RDMA_MSB       = 5;
    localparam int         PAGE_LSB       = 6;
    localparam int         PAGE_MSB       = 7;
    localparam logic [2:0] RDMA_RESET     = 3'h4;
    localparam logic [1:0] PAGE_RESET     = 2'h0;

    // ****************************************************************
    // remote dma command encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        NICC_RDMA_NONE  = 3'b000,
        NICC_RDMA_READ  = 3'b001,
        NICC_RDMA_WRITE = 3'b010,
        NICC_RDMA_SEND  = 3'b011,
        NICC_RDMA_ABORT = 3'b100
    } nicc_rdma_t;

    // ****************************************************************
    // core run state
    // ****************************************************************
    typedef enum logic [1:0] {
        NICC_STOPPED  = 2'b00,
        NICC_RUNNING  = 2'b01,
        NICC_DRAINING = 2'b10
    } nicc_state_t;

    // host register port
    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } nicc_host_t;

    // strobes toward the dma engine
    typedef struct packed {
        logic       rd_start;
        logic       wr_start;
        logic       send_start;
        logic       abort;
        logic       finish_now;
    } nicc_dma_t;
endpackage

// >>> design/nicc_rdma_decode.sv
// nicc_rdma_decode: turns a remote dma command write into strobes
`timescale 1ns/1ps
`default_nettype none
module nicc_rdma_decode
    import nicc_pkg::*;
(
    // write event
    input  wire logic       wr_en,
    input  wire logic [2:0] cmd,
    input  wire logic       xmit_set,
    input  wire logic       count_reloaded,
    // strobes
    output nicc_dma_t       dma
);
    wire abort_cmd = cmd[2];
    wire is_read   = (cmd == NICC_RDMA_READ);
    wire is_write  = (cmd == NICC_RDMA_WRITE);
    wire is_send   = (cmd == NICC_RDMA_SEND);

    assign dma.abort      = wr_en & abort_cmd;
    assign dma.rd_start   = wr_en & is_read;
    assign dma.wr_start   = wr_en & is_write;
    assign dma.send_start = wr_en & is_send;
    // reissue with transmit and no count reload ends the dma at once
    assign dma.finish_now = wr_en & xmit_set & ~abort_cmd
                          & (cmd != NICC_RDMA_NONE) & ~count_reloaded;
endmodule
`default_nettype wire

// >>> testbench/nicc_engine_model.sv
// nicc_engine_model: stand-in for the transmit and receive engines
`timescale 1ns/1ps
`default_nettype none
module nicc_engine_model #(
    parameter int LEN = 60
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // commands
    input  wire logic tx_launch,
    input  wire logic rx_go,
    input  wire logic abort_go,
    // engine status
    output logic      tx_busy,
    output logic      rx_busy,
    output logic      tx_done,
    output logic      tx_abort
);
    int tx_n;
    int rx_n;

    assign tx_busy = (tx_n != 0);
    assign rx_busy = (rx_n != 0);

    // frames run to their end, stop or not, unless abort_go cuts a transmit frame short
    always @(posedge clk) begin
        if (rst) begin
            tx_n     <= 0;
            rx_n     <= 0;
            tx_done  <= 1'b0;
            tx_abort <= 1'b0;
        end else begin
            tx_abort <= !tx_launch && (tx_n != 0) && abort_go;
            tx_done  <= !tx_launch && !abort_go && (tx_n == 1);
            if (tx_launch) begin
                tx_n <= LEN;
            end else if (tx_n != 0 && abort_go) begin
                tx_n <= 0;
            end else if (tx_n == 1) begin
                tx_n <= 0;
            end else if (tx_n != 0) begin
                tx_n <= tx_n - 1;
            end
            if (rx_go) begin
                rx_n <= LEN;
            end else if (rx_n != 0) begin
                rx_n <= rx_n - 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// testbench: command register checks through the host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nicc_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    nicc_host_t h = '0;
    logic       rx_go = 1'b0;
    logic       ab_go = 1'b0;
    logic       reload = 1'b0;
    logic       tx_busy, rx_busy, tx_done, tx_abort;
    logic       cmd_sel, core_enable, tx_launch, reset_done;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [1:0] page_sel;
    logic [2:0] rdma_cmd;
    nicc_dma_t  dma_ctl;
    wire  [6:0] ev = {reset_done, tx_launch, dma_ctl};
    int         cnt [7] = '{default: 0};
    int         num_errors = 0;
    int         n_tests = 0;

    always #10 clk = ~clk;

    // pulse counters: 0 fin 1 abort 2 send 3 wr 4 rd 5 launch 6 done
    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) begin
            if (ev[i] === 1'b1) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    nicc_command u_dut (
        .clk(clk), .rst(rst), .host_cs(h.cs), .host_wr(h.wr),
        .host_rd(h.rd), .host_addr(h.addr), .host_wdata(h.wdata),
        .host_rdata(rdata), .cmd_sel(cmd_sel), .rx_busy(rx_busy),
        .tx_busy(tx_busy), .tx_done(tx_done), .tx_abort(tx_abort),
        .dma_count_reloaded(reload), .core_enable(core_enable),
        .tx_launch(tx_launch), .reset_done(reset_done),
        .page_sel(page_sel), .rdma_cmd(rdma_cmd), .dma_ctl(dma_ctl)
    );

    nicc_engine_model #(.LEN(60)) u_eng (
        .clk(clk), .rst(rst), .tx_launch(tx_launch), .rx_go(rx_go),
        .abort_go(ab_go), .tx_busy(tx_busy), .rx_busy(rx_busy),
        .tx_done(tx_done), .tx_abort(tx_abort)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        h <= '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(6);
        h <= '0;
        cyc(4);
    endtask

    task automatic rd(output logic [7:0] d);
        h <= '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: 4'h0, wdata: 8'h00};
        cyc(6);
        h <= '0;
        cyc(2);
        d = rdata;
    endtask

    task automatic idle;
        int i;
        i = 0;
        while ((tx_busy | rx_busy) !== 1'b0 && i < 200) begin
            cyc(1);
            i++;
        end
        cyc(4);
    endtask

    task automatic chk_reg(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            num_errors++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        rd(v);
        chk_reg("command", 8'h21, v);
        chk_reg("dma field", 8'h04, {5'h0, rdma_cmd});
        h.addr <= 4'h5;
        cyc(4);
        chk_reg("cmd_sel", 8'h00, {7'h0, cmd_sel});
        h.addr <= 4'h0;
        cyc(4);
        chk_reg("cmd_sel", 8'h01, {7'h0, cmd_sel});
        wr(4'h0, 8'h22);
        chk_reg("enable", 8'h01, {7'h0, core_enable});
        chk_cnt("abort", 1, cnt[1]);
        wr(4'h4, 8'h40);
        wr(4'h5, 8'h3c);
        wr(4'h0, 8'h26);
        chk_cnt("launch", 1, cnt[5]);
        wr(4'h0, 8'h62);
        chk_reg("page", 8'h01, {6'h0, page_sel});
        rd(v);
        chk_reg("pending", 8'h66, v);
        idle();
        rd(v);
        chk_reg("sent", 8'h62, v);
        for (int p = 0; p < 4; p++) begin
            wr(4'h0, {p[1:0], 6'h22});
            chk_reg("page", p[7:0], {6'h0, page_sel});
        end
        for (int c = 0; c < 8; c++) begin
            wr(4'h0, {2'h0, c[2:0], 3'h2});
            chk_reg("dma field", c[7:0], {5'h0, rdma_cmd});
            wr(4'h0, 8'h22);
        end
        chk_cnt("read start", 1, cnt[4]);
        chk_cnt("write start", 1, cnt[3]);
        chk_cnt("send start", 1, cnt[2]);
        chk_cnt("abort", 19, cnt[1]);
        wr(4'h0, 8'h0e);
        chk_cnt("finish", 1, cnt[0]);
        ab_go <= 1'b1;
        idle();
        ab_go <= 1'b0;
        rd(v);
        chk_reg("aborted", 8'h0a, v);
        wr(4'ha, 8'h00);
        wr(4'hb, 8'h00);
        wr(4'h0, 8'h22);
        rx_go <= 1'b1;
        cyc(1);
        rx_go <= 1'b0;
        wr(4'h0, 8'h21);
        chk_reg("enable", 8'h00, {7'h0, core_enable});
        chk_cnt("reset done", 0, cnt[6]);
        idle();
        chk_cnt("reset done", 1, cnt[6]);
        rd(v);
        chk_reg("halted", 8'h23, v);
        wr(4'h0, 8'h25);
        chk_cnt("launch", 2, cnt[5]);
        reload <= 1'b1;
        wr(4'h0, 8'h0d);
        reload <= 1'b0;
        chk_cnt("finish", 1, cnt[0]);
        wr(4'h0, 8'h21);
        chk_cnt("reset done", 1, cnt[6]);
        wr(4'h5, 8'h22);
        chk_reg("enable", 8'h00, {7'h0, core_enable});
        wr(4'h0, 8'h22);
        chk_reg("enable", 8'h01, {7'h0, core_enable});
        finish_test();
    end
endmodule
`default_nettype wire
